/* usi_core.sv */
`timescale 1ns/1ps
`include "usi_defs.svh"
// Contract
// - Mode 4 selects T0, 5 selects T1.
// - T0 character: start, eight data, parity, guard.
// - Transmitter releases line during guard time.
// - Receiver parity error drives one low bit.
// - T0 parity error discards character, sets flag.
// - Tally errors up to 255, read clears.
// - Inhibit: no error bit, set inhibit flag.
// - Inhibit: store character, no ready flag.
// - Repeat NACKed character up to limit times.
// - Flag when repetitions reach the limit.
// - Acknowledge stops repeats, clears counter.
// - Control clear command clears repeat flag.
// - NACK limit reached: accept, acknowledge, flag.
// - T1: one stop bit, parity generated, checked.
// - Infrared zero is three-sixteenths bit pulse.
// - Filter counter loads, falls count down.
// - Rising edge stops and reloads counter.
// - Counter zero drives receiver low one bit.
// - Driver control equals inverse transmitter idle.
// - Driver control high through timeguard.
module usi_core
    import usi_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        rxd_i,
    output logic             txd_o,
    output logic             txd_oe,
    output logic             rts_o
);

    usi_state_t  st_r;
    usi_state_t  st_nxt;
    logic        t0;
    logic        iso;
    logic        irda;
    logic [15:0] bitlen;
    logic [17:0] pmul;
    logic [15:0] plen;
    logic        rx_line;
    logic        tx_end;
    logic        rx_end;
    logic        perr;
    logic        lim_hit;

    // ****************************************************************
    // Mode decode and bit timing.
    // ****************************************************************
    // mode decode.
    assign t0     = st_r.mode == `USI_MODE_T0;
    assign iso    = t0 || (st_r.mode == `USI_MODE_T1);
    assign irda   = st_r.mode == `USI_MODE_IRDA;
    assign bitlen = iso ? {5'h0, st_r.fidi} : st_r.cd;
    assign pmul   = {2'h0, bitlen} * `USI_IR_NUM;
    assign plen   = pmul[17:2] >> 2;
    assign tx_end = st_r.tx_cnt == bitlen - 16'h1;
    assign rx_end = st_r.rx_cnt == bitlen - 16'h1;
    assign rx_line = irda ? !st_r.dem_low : st_r.s2;
    assign perr    = ^st_r.rx_sh;
    assign lim_hit = st_r.successive_nack_limit && (st_r.rx_nacks == st_r.max_iter);

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = rxd_i;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        st_nxt.rdata = 32'h0;

        // ****************************************************************
        // Register port; clears come first so events below win.
        // ****************************************************************
        if (reg_wr) begin
            unique case (reg_addr)
                `USI_OFF_CTRL: begin
                    if (reg_wdata[`USI_CR_RXDIS]) st_nxt.rx_en = 1'b0;
                    else if (reg_wdata[`USI_CR_RXEN]) st_nxt.rx_en = 1'b1;
                    if (reg_wdata[`USI_CR_TXDIS]) st_nxt.tx_en = 1'b0;
                    else if (reg_wdata[`USI_CR_TXEN]) st_nxt.tx_en = 1'b1;
                    if (reg_wdata[`USI_CR_RSTSTA]) st_nxt.parity_error_flag = 1'b0;
                    if (reg_wdata[`USI_CR_CLR_REP]) st_nxt.iter_flag = 1'b0;
                    if (reg_wdata[`USI_CR_CLR_INH]) st_nxt.nack_inhibit = 1'b0;
                end
                `USI_OFF_MODE: begin
                    st_nxt.mode     = reg_wdata[3:0];
                    st_nxt.inhibit  = reg_wdata[`USI_MR_INH];
                    st_nxt.successive_nack_limit   = reg_wdata[`USI_MR_DSN];
                    st_nxt.max_iter = reg_wdata[`USI_MR_ITER_HI:`USI_MR_ITER_LO];
                end
                `USI_OFF_THR: begin
                    st_nxt.thr      = reg_wdata[7:0];
                    st_nxt.thr_full = 1'b1;
                end
                `USI_OFF_BRGR: st_nxt.cd   = reg_wdata[15:0];
                `USI_OFF_TTGR: st_nxt.tg   = reg_wdata[7:0];
                `USI_OFF_FIDI: st_nxt.fidi = reg_wdata[10:0];
                `USI_OFF_IF:   st_nxt.ifv  = reg_wdata[7:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `USI_OFF_MODE: begin
                    st_nxt.rdata[3:0] = st_r.mode;
                    st_nxt.rdata[`USI_MR_INH] = st_r.inhibit;
                    st_nxt.rdata[`USI_MR_DSN] = st_r.successive_nack_limit;
                    st_nxt.rdata[`USI_MR_ITER_HI:`USI_MR_ITER_LO] = st_r.max_iter;
                end
                `USI_OFF_STAT: begin
                    st_nxt.rdata[`USI_SR_RECEIVE_READY_FLAG]   = st_r.receive_ready_flag;
                    st_nxt.rdata[`USI_SR_TXRDY]   = !st_r.thr_full;
                    st_nxt.rdata[`USI_SR_PARITY_ERROR_FLAG]    = st_r.parity_error_flag;
                    st_nxt.rdata[`USI_SR_TRANSMITTER_IDLE_FLAG] = (st_r.tx_st == TX_IDLE) && !st_r.thr_full;
                    st_nxt.rdata[`USI_SR_ITER]    = st_r.iter_flag;
                    st_nxt.rdata[`USI_SR_NACK_INHIBIT]   = st_r.nack_inhibit;
                end
                `USI_OFF_RHR: begin
                    st_nxt.rdata[7:0] = st_r.rhr;
                    st_nxt.receive_ready_flag      = 1'b0;
                end
                `USI_OFF_BRGR: st_nxt.rdata[15:0] = st_r.cd;
                `USI_OFF_TTGR: st_nxt.rdata[7:0]  = st_r.tg;
                `USI_OFF_FIDI: st_nxt.rdata[10:0] = st_r.fidi;
                `USI_OFF_NER: begin
                    st_nxt.rdata[7:0] = st_r.tally;
                    st_nxt.tally = 8'h0;
                end
                `USI_OFF_IF: st_nxt.rdata[7:0] = st_r.ifv;
                default: ;
            endcase
        end

        // ****************************************************************
        // Transmitter.
        // ****************************************************************
        unique case (st_r.tx_st)
            TX_IDLE: begin
                if (st_r.tx_en && st_r.thr_full) begin
                    st_nxt.tx_sh   = {1'b1, ^st_r.thr, st_r.thr, 1'b0};
                    st_nxt.tx_char = st_r.thr;
                    st_nxt.iter    = 3'h0;
                    st_nxt.tx_cnt  = 16'h0;
                    st_nxt.tx_bit  = 4'h0;
                    st_nxt.tx_st   = TX_BIT;
                    if (!(reg_wr && reg_addr == `USI_OFF_THR)) st_nxt.thr_full = 1'b0;
                end
            end
            TX_BIT: begin
                st_nxt.tx_cnt = st_r.tx_cnt + 16'h1;
                if (tx_end) begin
                    st_nxt.tx_cnt = 16'h0;
                    st_nxt.tx_bit = st_r.tx_bit + 4'h1;
                    if (t0 && st_r.tx_bit == `USI_IDX_PAR) begin
                        st_nxt.tx_bit    = 4'h0;
                        st_nxt.nack_seen = 1'b0;
                        st_nxt.tx_st     = TX_GUARD;
                    end else if (st_r.tx_bit == `USI_IDX_STOP) begin
                        st_nxt.tx_bit = 4'h0;
                        st_nxt.tx_st  = (st_r.tg != 8'h0) ? TX_TG : TX_IDLE;
                    end
                end
            end
            TX_GUARD: begin
                st_nxt.tx_cnt = st_r.tx_cnt + 16'h1;
                if (st_r.tx_bit == 4'h0 && st_r.tx_cnt == (bitlen >> 1) && !st_r.s2) begin
                    st_nxt.nack_seen = 1'b1;
                end
                if (tx_end) begin
                    st_nxt.tx_cnt = 16'h0;
                    st_nxt.tx_bit = st_r.tx_bit + 4'h1;
                    if (st_r.tx_bit == (st_r.nack_seen ? 4'h2 : 4'h1)) begin
                        st_nxt.tx_bit = 4'h0;
                        st_nxt.tx_st  = (st_r.tg != 8'h0) ? TX_TG : TX_IDLE;
                        if (!st_r.nack_seen) begin
                            st_nxt.iter = 3'h0;
                        end else if (st_r.max_iter != 3'h0 && st_r.iter < st_r.max_iter) begin
                            st_nxt.iter  = st_r.iter + 3'h1;
                            st_nxt.tx_sh = {1'b1, ^st_r.tx_char, st_r.tx_char, 1'b0};
                            st_nxt.tx_st = TX_BIT;
                            if (st_r.iter + 3'h1 == st_r.max_iter) st_nxt.iter_flag = 1'b1;
                        end
                    end
                end
            end
            TX_TG: begin
                st_nxt.tx_cnt = st_r.tx_cnt + 16'h1;
                if (tx_end) begin
                    st_nxt.tx_cnt = 16'h0;
                    st_nxt.tx_bit = st_r.tx_bit + 4'h1;
                    if ({4'h0, st_r.tx_bit} == st_r.tg - 8'h1) begin
                        st_nxt.tx_bit = 4'h0;
                        st_nxt.tx_st  = TX_IDLE;
                    end
                end
            end
        endcase

        // ****************************************************************
        // Receiver.
        // ****************************************************************
        unique case (st_r.rx_st)
            RX_IDLE: begin
                if (st_r.rx_en && !rx_line) begin
                    st_nxt.rx_cnt = 16'h0;
                    st_nxt.rx_bit = 4'h0;
                    st_nxt.rx_st  = RX_BIT;
                end
            end
            RX_BIT: begin
                st_nxt.rx_cnt = st_r.rx_cnt + 16'h1;
                if (st_r.rx_cnt == (bitlen >> 1) && st_r.rx_bit != 4'h0) st_nxt.rx_sh = {rx_line, st_r.rx_sh[8:1]};
                if (rx_end) begin
                    st_nxt.rx_cnt = 16'h0;
                    st_nxt.rx_bit = st_r.rx_bit + 4'h1;
                    if (st_r.rx_bit == `USI_IDX_PAR) begin
                        st_nxt.rx_bit = 4'h0;
                        st_nxt.rx_st  = t0 ? RX_IDLE : RX_STOP;
                        if (!perr) begin
                            st_nxt.rhr      = st_r.rx_sh[7:0];
                            st_nxt.receive_ready_flag    = 1'b1;
                            st_nxt.rx_nacks = 3'h0;
                        end else begin
                            st_nxt.parity_error_flag = 1'b1;
                            if (st_nxt.tally != `USI_TALLY_MAX) st_nxt.tally = st_nxt.tally + 8'h1;
                            if (!t0) begin
                                st_nxt.rhr   = st_r.rx_sh[7:0];
                                st_nxt.receive_ready_flag = 1'b1;
                            end else if (st_r.inhibit) begin
                                st_nxt.rhr   = st_r.rx_sh[7:0];
                                st_nxt.nack_inhibit = 1'b1;
                            end else if (lim_hit) begin
                                st_nxt.rhr       = st_r.rx_sh[7:0];
                                st_nxt.receive_ready_flag     = 1'b1;
                                st_nxt.iter_flag = 1'b1;
                                st_nxt.rx_nacks  = 3'h0;
                            end else begin
                                st_nxt.rx_nacks = st_r.rx_nacks + 3'h1;
                                st_nxt.rx_st    = RX_NACK;
                            end
                        end
                    end
                end
            end
            RX_NACK, RX_GUARD, RX_STOP: begin
                st_nxt.rx_cnt = st_r.rx_cnt + 16'h1;
                if (rx_end) begin
                    st_nxt.rx_cnt = 16'h0;
                    st_nxt.rx_st  = (st_r.rx_st == RX_NACK) ? RX_GUARD : RX_IDLE;
                end
            end
        endcase

        // ****************************************************************
        // Infrared demodulator filter.
        // ****************************************************************
        if (!irda) begin
            st_nxt.flt     = st_r.ifv;
            st_nxt.flt_run = 1'b0;
            st_nxt.dem_low = 1'b0;
        end else begin
            if (st_r.dem_low) begin
                st_nxt.dem_cnt = st_r.dem_cnt + 16'h1;
                if (st_r.dem_cnt == bitlen - 16'h1) st_nxt.dem_low = 1'b0;
            end
            if (!st_r.s3 && st_r.s2) begin
                st_nxt.flt_run = 1'b0;
                st_nxt.flt     = st_r.ifv;
            end else if (st_r.s3 && !st_r.s2) begin
                st_nxt.flt_run = 1'b1;
                st_nxt.flt     = st_r.ifv;
            end else if (st_r.flt_run) begin
                if (st_r.flt == 8'h0) begin
                    st_nxt.flt_run = 1'b0;
                    st_nxt.flt     = st_r.ifv;
                    st_nxt.dem_low = 1'b1;
                    st_nxt.dem_cnt = 16'h0;
                end else begin
                    st_nxt.flt = st_r.flt - 8'h1;
                end
            end
        end

        // ****************************************************************
        // Pin drive, taken from the next state so pins come from flops.
        // ****************************************************************
        if (st_nxt.rx_st == RX_NACK) begin
            st_nxt.txd_en = 1'b1;
            st_nxt.txd    = 1'b0;
        end else if (iso) begin
            st_nxt.txd_en = st_nxt.tx_st == TX_BIT;
            st_nxt.txd    = st_nxt.tx_sh[st_nxt.tx_bit];
        end else if (irda) begin
            st_nxt.txd_en = 1'b1;
            st_nxt.txd    = (st_nxt.tx_st == TX_BIT) && !st_nxt.tx_sh[st_nxt.tx_bit]
                            && (st_nxt.tx_cnt < plen);
        end else begin
            st_nxt.txd_en = 1'b1;
            st_nxt.txd    = (st_nxt.tx_st == TX_BIT) ? st_nxt.tx_sh[st_nxt.tx_bit] : 1'b1;
        end
        st_nxt.rts = (st_nxt.mode == `USI_MODE_RS485)
                     && !((st_nxt.tx_st == TX_IDLE) && !st_nxt.thr_full);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r      <= '0;
            st_r.fidi <= `USI_RST_FIDI;
            st_r.txd  <= 1'b1;
            st_r.s1   <= 1'b1;
            st_r.s2   <= 1'b1;
            st_r.s3   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign txd_o     = st_r.txd;
    assign txd_oe    = st_r.txd_en;
    assign rts_o     = st_r.rts;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence perr_t0_end;
        st_r.rx_st == RX_BIT && rx_end && st_r.rx_bit == `USI_IDX_PAR && perr && t0;
    endsequence

    sequence nack_bit;
        st_r.rx_st == RX_NACK && txd_oe && !txd_o;
    endsequence

    chk_guard_release: assert property (
        st_r.tx_st == TX_GUARD && st_r.rx_st != RX_NACK |-> !txd_oe && t0)
        else $error("line driven during guard time");

    chk_discard_char: assert property (
        perr_t0_end ##0 !st_r.inhibit && !lim_hit && !reg_rd |=> st_r.parity_error_flag && $stable(st_r.rhr))
        else $error("erroneous character not discarded");

    chk_nack_len: assert property (
        perr_t0_end ##0 !st_r.inhibit && !lim_hit && bitlen > 16'h1 |=> nack_bit ##1 nack_bit)
        else $error("error bit length wrong");

    chk_nack_end: assert property (
        st_r.rx_st == RX_NACK && rx_end |=> st_r.rx_st == RX_GUARD && !txd_oe)
        else $error("error bit not released after one bit");

    chk_inhibit_quiet: assert property (
        perr_t0_end ##0 st_r.inhibit && !reg_rd |=> st_r.nack_inhibit && $stable(st_r.receive_ready_flag) && st_r.rx_st != RX_NACK)
        else $error("inhibit mode misbehaved");

    chk_tally_clear: assert property (
        reg_rd && reg_addr == `USI_OFF_NER && !(st_r.rx_st == RX_BIT && rx_end) |=> st_r.tally == 8'h0)
        else $error("error tally not cleared by read");

    chk_repeat_clear: assert property (
        reg_wr && reg_addr == `USI_OFF_CTRL && reg_wdata[`USI_CR_CLR_REP]
        && st_r.tx_st != TX_GUARD && st_r.rx_st != RX_BIT |=> !st_r.iter_flag)
        else $error("repeat flag not cleared");

    chk_repeat_bound: assert property (
        st_r.tx_st != TX_IDLE |-> st_r.iter <= st_r.max_iter)
        else $error("repetitions exceed limit");

    chk_rts_guard: assert property (
        st_r.mode == `USI_MODE_RS485 && st_r.tx_st == TX_TG |-> rts_o)
        else $error("driver control dropped in timeguard");

    chk_irda_low: assert property (
        irda && st_r.flt_run && st_r.flt == 8'h0 && st_r.s2 == st_r.s3 |=> st_r.dem_low && !rx_line)
        else $error("demodulator missed pulse");
endmodule // usi_core

/* usi_defs.svh */
`ifndef USI_DEFS_SVH
`define USI_DEFS_SVH
`define USI_OFF_CTRL    8'h00
`define USI_OFF_MODE    8'h04
`define USI_OFF_STAT    8'h14
`define USI_OFF_RHR     8'h18
`define USI_OFF_THR     8'h1c
`define USI_OFF_BRGR    8'h20
`define USI_OFF_TTGR    8'h28
`define USI_OFF_FIDI    8'h40
`define USI_OFF_NER     8'h44
`define USI_OFF_IF      8'h4c
`define USI_MODE_RS485  4'h1
`define USI_MODE_T0     4'h4
`define USI_MODE_T1     4'h5
`define USI_MODE_IRDA   4'h8
`define USI_CR_RXEN     4
`define USI_CR_RXDIS    5
`define USI_CR_TXEN     6
`define USI_CR_TXDIS    7
`define USI_CR_RSTSTA   8
`define USI_CR_CLR_REP  13
`define USI_CR_CLR_INH  14
`define USI_MR_INH      20
`define USI_MR_DSN      21
`define USI_MR_ITER_LO  24
`define USI_MR_ITER_HI  26
`define USI_SR_RECEIVE_READY_FLAG    0
`define USI_SR_TXRDY    1
`define USI_SR_PARITY_ERROR_FLAG     7
`define USI_SR_TRANSMITTER_IDLE_FLAG  9
`define USI_SR_ITER     10
`define USI_SR_NACK_INHIBIT    13
`define USI_RST_FIDI    11'h174
`define USI_TALLY_MAX   8'hff
`define USI_IDX_PAR     4'h9
`define USI_IDX_STOP    4'ha
`define USI_IR_NUM      18'h3
`endif

/* usi_pkg.sv */
package usi_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_BIT, TX_GUARD, TX_TG} usi_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_BIT, RX_NACK, RX_GUARD, RX_STOP} usi_rx_t;
    typedef struct packed {
        usi_tx_t     tx_st;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [10:0] tx_sh;
        logic [7:0]  tx_char;
        logic [7:0]  thr;
        logic        thr_full;
        logic [2:0]  iter;
        logic        nack_seen;
        usi_rx_t     rx_st;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [8:0]  rx_sh;
        logic [7:0]  rhr;
        logic        receive_ready_flag;
        logic        parity_error_flag;
        logic        nack_inhibit;
        logic        iter_flag;
        logic [7:0]  tally;
        logic [2:0]  rx_nacks;
        logic        rx_en;
        logic        tx_en;
        logic [3:0]  mode;
        logic        inhibit;
        logic        successive_nack_limit;
        logic [2:0]  max_iter;
        logic [15:0] cd;
        logic [7:0]  tg;
        logic [10:0] fidi;
        logic [7:0]  ifv;
        logic [7:0]  flt;
        logic        flt_run;
        logic [15:0] dem_cnt;
        logic        dem_low;
        logic        s1;
        logic        s2;
        logic        s3;
        logic [31:0] rdata;
        logic        txd;
        logic        txd_en;
        logic        rts;
    } usi_state_t;
endpackage

/* usi_card.sv */
`timescale 1ns/1ps
module usi_card (
    input  wire logic core_clk,
    input  wire logic txd_o,
    input  wire logic txd_oe,
    input  wire logic nack_en,
    output logic      line
);
    logic card_low = 1'b0;
    int   bitlen   = 16;
    // The I/O line is open drain with a pull-up, so any party driving low wins.
    assign line = !((txd_oe && !txd_o) || card_low);
    always @(negedge txd_oe) begin
        if (nack_en) begin
            card_low <= 1'b1;
            repeat (bitlen) @(posedge core_clk);
            card_low <= 1'b0;
        end
    end
    task automatic send(input logic [7:0] d, input logic bad, output logic nack);
        logic [9:0] f;
        f = {^d ^ bad, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            card_low <= !f[i];
            repeat (bitlen) @(posedge core_clk);
        end
        card_low <= 1'b0;
        repeat (bitlen / 2) @(posedge core_clk);
        nack = !line;
        repeat (bitlen * 3) @(posedge core_clk);
    endtask
endmodule // usi_card

/* usi_core_test.sv */
`timescale 1ns/1ps
module usi_core_test;
    logic        core_clk  = 1'b0;
    logic        reset_n   = 1'b0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        nack_en   = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, rv;
    logic        txd_o, txd_oe, rts_o, line, nk;
    int          mismatches = 0, tests_run = 0, cycles = 0, starts = 0;
    always #4 core_clk = ~core_clk;
    usi_core i_usi_core (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_i(line), .txd_o(txd_o), .txd_oe(txd_oe),
        .rts_o(rts_o));
    usi_card i_usi_card (.core_clk(core_clk), .txd_o(txd_o), .txd_oe(txd_oe), .nack_en(nack_en), .line(line));
    always @(posedge txd_oe) starts++;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task final_report;
        $display("counts tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic test_regs;
        logic [3:0] m[4] = '{4'h1, 4'h4, 4'h5, 4'h8};
        rd(8'h40, rv); chk(rv[10:0], 11'h174);
        rd(8'h30, rv); chk(rv, 32'h0);
        wr(8'h40, 32'h10);
        foreach (m[i]) begin wr(8'h04, {28'h0, m[i]}); rd(8'h04, rv); chk(rv[3:0], m[i]); end
        $display("test regs done");
    endtask
    task automatic test_t0_tx;
        nack_en = 1'b1; wr(8'h04, 32'h0200_0004); wr(8'h00, 32'h40); starts = 0;
        wr(8'h1c, 32'ha5); repeat (800) @(posedge core_clk);
        chk(starts, 3);
        rd(8'h14, rv); chk(rv[10], 1'b1);
        wr(8'h00, 32'h2000); rd(8'h14, rv); chk(rv[10], 1'b0);
        nack_en = 1'b0; starts = 0; wr(8'h1c, 32'h5a); repeat (300) @(posedge core_clk);
        chk(starts, 1);
        $display("test t0 tx done");
    endtask
    task automatic test_t0_rx;
        wr(8'h00, 32'h90); i_usi_card.send(8'h3c, 1'b1, nk);
        chk(nk, 1'b1);
        rd(8'h14, rv); chk({rv[7], rv[0]}, 2'b10);
        rd(8'h44, rv); chk(rv[7:0], 8'h01);
        rd(8'h44, rv); chk(rv[7:0], 8'h00);
        wr(8'h04, 32'h0010_0004); i_usi_card.send(8'hc3, 1'b1, nk);
        chk(nk, 1'b0);
        rd(8'h14, rv); chk({rv[13], rv[0]}, 2'b10);
        rd(8'h18, rv); chk(rv[7:0], 8'hc3);
        wr(8'h00, 32'h4000); rd(8'h14, rv); chk(rv[13], 1'b0);
        wr(8'h04, 32'h0220_0004); i_usi_card.send(8'h66, 1'b1, nk);
        chk(nk, 1'b1);
        i_usi_card.send(8'h66, 1'b1, nk);
        chk(nk, 1'b0);
        rd(8'h14, rv); chk({rv[10], rv[0]}, 2'b11);
        rd(8'h18, rv); chk(rv[7:0], 8'h66);
        $display("test t0 rx done");
    endtask
    task automatic test_t1;
        wr(8'h04, 32'h5); wr(8'h00, 32'h190); i_usi_card.send(8'h96, 1'b1, nk);
        chk(nk, 1'b0);
        rd(8'h14, rv); chk({rv[7], rv[0]}, 2'b11);
        rd(8'h18, rv); chk(rv[7:0], 8'h96);
        $display("test t1 done");
    endtask
    task automatic test_irda;
        int n;
        n = 0;
        wr(8'h04, 32'h8); wr(8'h20, 32'h10); wr(8'h00, 32'h60); wr(8'h1c, 32'h0);
        repeat (260) @(negedge core_clk) n += txd_o;
        chk(n, 30);
        $display("test irda done");
    endtask
    task automatic test_rs485;
        wr(8'h04, 32'h1); wr(8'h20, 32'h8); wr(8'h00, 32'h60); wr(8'h28, 32'h2); wr(8'h1c, 32'h11);
        repeat (4) @(negedge core_clk);
        chk(rts_o, 1'b1);
        rd(8'h14, rv); chk(rv[9], 1'b0);
        repeat (85) @(negedge core_clk);
        chk(rts_o, 1'b1);
        rd(8'h14, rv); chk(rv[9], 1'b0);
        repeat (60) @(negedge core_clk);
        chk(rts_o, 1'b0);
        $display("test rs485 done");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        test_regs();
        test_t0_tx();
        test_t0_rx();
        test_t1();
        test_rs485();
        test_irda();
        final_report();
    end
endmodule // usi_core_test
